// ==== bitfield_and_viterbi_acs_unit.sv ====
// execution datapath: bit-field scatter and gather, dual metric arithmetic, max-select, xor-shift
//
// Summary of operation
// (RL1) Scatter clears the result and walks mask bits 0 to 15, copying a source bit on a set bit, in one cycle.
// (RL2) Gather clears the result and walks mask bits 0 to 15, packing selected source bits low, in one cycle.
// (RL3) Both bit-field operations take their source bits from the low 32 bits of a 40-bit accumulator.
// (RL4) Dual mode computes the upper and lower accumulator halves independently in one operation.
// (RL5) Add-subtract adds the distance to one old metric and subtracts it from the paired one.
// (RL6) Subtract-add does the reverse and writes to a separate destination accumulator.
// (RL7) Max-select compares upper halves and lower halves of two accumulators and keeps each larger value.
// (RL8) Max-select finishes the whole compare-select step in a single cycle.
// (RL9) Software loads the distance temporary register before a dual arithmetic operation uses it.
// (RL10) Encoder streams come from xoring an accumulator with a shifted copy; a negative immediate shifts right.
// (RL11) The encoder reference is constraint length five, rate one half, taps 0,3,4 and 0,1,3,4.
// (RL12) Software codes expected outputs antipodally so distances are sums and differences.
// (RL13) Add-subtract puts metric plus distance in bits 39-16 and metric minus distance in bits 15-0.
// (RL14) Each max-select shifts its two selection bits into an upper and a lower path history.
// (RL15) On equal halves max-select keeps the first source and records a zero selection bit.
// (RL16) Every result is in its destination by the next issue slot with no stall.
`timescale 1ns/1ps
module bitfield_and_viterbi_acs_unit
  import acs_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          arst_n,
  input  wire logic                          op_valid,
  input  wire op_t                           opcode,
  input  wire logic [SEL_W-1:0]              src_a_sel,
  input  wire logic [SEL_W-1:0]              src_b_sel,
  input  wire logic [SEL_W-1:0]              dst_sel,
  input  wire logic [MASK_W-1:0]             select_mask_immediate,
  input  wire logic                          xor_shift_en,
  input  wire logic [ACC_W-1:0]              load_data,
  output logic      [NUM_ACC-1:0][ACC_W-1:0] acc_out,
  output logic      [HALF_W-1:0]             distance_temp_register,
  output logic      [HALF_W-1:0]             upper_path_history,
  output logic      [HALF_W-1:0]             lower_path_history
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [NUM_ACC-1:0][ACC_W-1:0] acc_q;
  logic [NUM_ACC-1:0][ACC_W-1:0] acc_d;
  logic [HALF_W-1:0]             dist_q;
  logic [HALF_W-1:0]             dist_d;
  logic [HALF_W-1:0]             hist_hi_q;
  logic [HALF_W-1:0]             hist_hi_d;
  logic [HALF_W-1:0]             hist_lo_q;
  logic [HALF_W-1:0]             hist_lo_d;

  logic [ACC_W-1:0]              accumulator_operand;
  logic [ACC_W-1:0]              operand_b;
  logic [ACC_W-1:0]              operand_dst;
  logic [MASK_W-1:0]             field_res;
  field_mode_t                   field_mode;
  logic                          shift_neg;
  logic [SHIFT_W-1:0]            shift_mag;
  logic [ACC_W-1:0]              shifted;
  logic [ACC_W-1:0]              xor_res;

  dual_half_if dual_bus ();

  assign accumulator_operand = acc_q[src_a_sel];
  assign operand_b           = acc_q[src_b_sel];
  assign operand_dst         = acc_q[dst_sel];

  // ---------------------------------------------------------------
  // bit-field engine
  // ---------------------------------------------------------------
  assign field_mode = (opcode == GATHER_OPCODE) ? FIELD_GATHER : FIELD_SCATTER;

  bitfield_unit u_bitfield (
    .src    (accumulator_operand[SRC_MSB:0]), // RL3
    .mask   (select_mask_immediate),
    .mode   (field_mode),
    .result (field_res)
  );

  // ---------------------------------------------------------------
  // dual half-word engine
  // ---------------------------------------------------------------
  assign dual_bus.pair_word      = accumulator_operand[SRC_MSB:0];
  assign dual_bus.local_distance = dist_q;
  assign dual_bus.cmp_a          = accumulator_operand[SRC_MSB:0];
  assign dual_bus.cmp_b          = operand_b[SRC_MSB:0];

  dual_acs_engine u_dual (
    .io (dual_bus)
  );

  // ---------------------------------------------------------------
  // xor with shifted copy; shift field is a signed six-bit count
  // ---------------------------------------------------------------
  assign shift_neg = select_mask_immediate[SHIFT_W-1];
  assign shift_mag = shift_neg ? (~select_mask_immediate[SHIFT_W-1:0] + 6'h01)
                               : select_mask_immediate[SHIFT_W-1:0];
  assign shifted   = shift_neg ? (accumulator_operand >> shift_mag)
                               : (accumulator_operand << shift_mag); // RL10
  // generator taps are built by chaining these, e.g. -3 then -4 for delays 3 and 4
  assign xor_res   = operand_dst ^ shifted; // RL10 RL11

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    acc_d     = acc_q;
    dist_d    = dist_q;
    hist_hi_d = hist_hi_q;
    hist_lo_d = hist_lo_q;
    if (op_valid && xor_shift_en)
    begin
      acc_d[dst_sel] = xor_res; // RL10
    end
    else if (op_valid)
    begin
      unique case (opcode)
        OP_NOP:
        begin
          acc_d = acc_q;
        end
        OP_LOAD:
        begin
          acc_d[dst_sel] = load_data;
        end
        OP_SET_DISTANCE:
        begin
          dist_d = select_mask_immediate; // RL9
        end
        SCATTER_OPCODE, GATHER_OPCODE:
        begin
          acc_d[dst_sel] = {{(ACC_W-MASK_W){1'b0}}, field_res}; // RL1 RL2 RL16
        end
        DUAL_ADD_SUB_OP:
        begin
          acc_d[dst_sel] = dual_bus.add_sub_res; // RL5 RL16
        end
        DUAL_SUB_ADD_OP:
        begin
          acc_d[dst_sel] = dual_bus.sub_add_res; // RL6 RL16
        end
        DUAL_MAX_SELECT_OP:
        begin
          acc_d[dst_sel] = dual_bus.max_res; // RL7 RL8
          hist_hi_d      = {hist_hi_q[HALF_W-2:0], dual_bus.sel_hi}; // RL14
          hist_lo_d      = {hist_lo_q[HALF_W-2:0], dual_bus.sel_lo}; // RL14
        end
      endcase
    end
  end

  // results land on this edge, so the next issued op reads them directly
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acc_q     <= {NUM_ACC{ACC_RST}};
      dist_q    <= DIST_RST;
      hist_hi_q <= HIST_RST;
      hist_lo_q <= HIST_RST;
    end
    else
    begin
      acc_q     <= acc_d;
      dist_q    <= dist_d;
      hist_hi_q <= hist_hi_d;
      hist_lo_q <= hist_lo_d;
    end
  end

  assign acc_out                = acc_q;
  assign distance_temp_register = dist_q;
  assign upper_path_history     = hist_hi_q;
  assign lower_path_history     = hist_lo_q;

  // ---------------------------------------------------------------
  // checking helpers: snapshot of the previous issue
  // ---------------------------------------------------------------
  logic              last_valid_q;
  op_t               last_op_q;
  logic              last_xor_q;
  logic [SEL_W-1:0]  last_dst_q;
  logic [MASK_W-1:0] last_imm_q;
  logic [ACC_W-1:0]  last_a_q;
  logic [ACC_W-1:0]  last_b_q;
  logic [ACC_W-1:0]  last_dstv_q;
  logic [HALF_W-1:0] last_dist_q;
  logic [ACC_W-1:0]  res;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      last_valid_q <= 1'b0;
      last_op_q    <= OP_NOP;
      last_xor_q   <= 1'b0;
      last_dst_q   <= '0;
      last_imm_q   <= '0;
      last_a_q     <= '0;
      last_b_q     <= '0;
      last_dstv_q  <= '0;
      last_dist_q  <= '0;
    end
    else
    begin
      last_valid_q <= op_valid;
      last_op_q    <= opcode;
      last_xor_q   <= xor_shift_en;
      last_dst_q   <= dst_sel;
      last_imm_q   <= select_mask_immediate;
      last_a_q     <= accumulator_operand;
      last_b_q     <= operand_b;
      last_dstv_q  <= operand_dst;
      last_dist_q  <= dist_q;
    end
  end

  assign res = acc_q[last_dst_q];

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_scatter_full_mask: assert property (@(posedge clk) disable iff (!arst_n) // RL1
    (last_valid_q && !last_xor_q && last_op_q == SCATTER_OPCODE && last_imm_q == 16'hffff)
      |-> res == {24'h00_0000, last_a_q[15:0]})
    else $error("scatter with full mask did not copy low half");

  a_scatter_spread_bits: assert property (@(posedge clk) disable iff (!arst_n) // RL1
    (last_valid_q && !last_xor_q && last_op_q == SCATTER_OPCODE && last_imm_q == 16'haaaa)
      |-> (res[1] == last_a_q[0] && res[3] == last_a_q[1] && res[15] == last_a_q[7]
           && res[0] == 1'b0 && res[39:16] == 24'h00_0000))
    else $error("scatter did not spread source bits to odd positions");

  a_gather_pack_bits: assert property (@(posedge clk) disable iff (!arst_n) // RL2 RL3
    (last_valid_q && !last_xor_q && last_op_q == GATHER_OPCODE && last_imm_q == 16'haaaa)
      |-> (res[0] == last_a_q[1] && res[1] == last_a_q[3] && res[7] == last_a_q[15]
           && res[39:8] == 32'h0000_0000))
    else $error("gather did not pack odd source bits low");

  a_add_sub_fields: assert property (@(posedge clk) disable iff (!arst_n) // RL5 RL13
    (last_valid_q && !last_xor_q && last_op_q == DUAL_ADD_SUB_OP)
      |-> (res[39:16] == 24'({{8{last_a_q[31]}}, last_a_q[31:16]} + {{8{last_dist_q[15]}}, last_dist_q})
           && res[15:0] == 16'(last_a_q[15:0] - last_dist_q)))
    else $error("add-subtract halves wrong");

  a_sub_add_fields: assert property (@(posedge clk) disable iff (!arst_n) // RL6 RL4
    (last_valid_q && !last_xor_q && last_op_q == DUAL_SUB_ADD_OP)
      |-> (res[39:16] == 24'({{8{last_a_q[31]}}, last_a_q[31:16]} - {{8{last_dist_q[15]}}, last_dist_q})
           && res[15:0] == 16'(last_a_q[15:0] + last_dist_q)))
    else $error("subtract-add halves wrong");

  a_max_select_halves: assert property (@(posedge clk) disable iff (!arst_n) // RL7 RL8
    (last_valid_q && !last_xor_q && last_op_q == DUAL_MAX_SELECT_OP)
      |-> ($signed(res[31:16]) >= $signed(last_a_q[31:16]) && $signed(res[31:16]) >= $signed(last_b_q[31:16])
           && $signed(res[15:0]) >= $signed(last_a_q[15:0]) && $signed(res[15:0]) >= $signed(last_b_q[15:0])
           && (res[15:0] == last_a_q[15:0] || res[15:0] == last_b_q[15:0])))
    else $error("max-select did not keep the larger halves");

  a_history_shift_in: assert property (@(posedge clk) disable iff (!arst_n) // RL14
    (op_valid && !xor_shift_en && opcode == DUAL_MAX_SELECT_OP)
      |=> (upper_path_history[15:1] == $past(upper_path_history[14:0])
           && lower_path_history[15:1] == $past(lower_path_history[14:0])))
    else $error("path history did not shift on max-select");

  a_tie_keeps_first: assert property (@(posedge clk) disable iff (!arst_n) // RL15
    (last_valid_q && !last_xor_q && last_op_q == DUAL_MAX_SELECT_OP && last_a_q[15:0] == last_b_q[15:0])
      |-> (lower_path_history[0] == 1'b0 && res[15:0] == last_a_q[15:0]))
    else $error("tie did not keep first source");

  a_xor_right_one: assert property (@(posedge clk) disable iff (!arst_n) // RL10
    (last_valid_q && last_xor_q && last_imm_q == 16'hffff)
      |-> res == (last_dstv_q ^ (last_a_q >> 1)))
    else $error("xor with shift of minus one wrong");

  a_idle_holds_acc: assert property (@(posedge clk) disable iff (!arst_n) // RL16
    (!op_valid || (!xor_shift_en && opcode == OP_NOP)) |=> acc_q == $past(acc_q))
    else $error("accumulators changed without an operation");

  a_load_lands: assert property (@(posedge clk) disable iff (!arst_n) // RL16
    (op_valid && !xor_shift_en && opcode == OP_LOAD)
      |=> acc_q[$past(dst_sel)] == $past(load_data))
    else $error("loaded value not in destination after one edge");

  a_distance_set: assert property (@(posedge clk) disable iff (!arst_n) // RL16
    (op_valid && !xor_shift_en && opcode == OP_SET_DISTANCE)
      |=> distance_temp_register == $past(select_mask_immediate))
    else $error("distance register not written after one edge");

  a_gather_full_mask: assert property (@(posedge clk) disable iff (!arst_n) // RL2 RL3
    (last_valid_q && !last_xor_q && last_op_q == GATHER_OPCODE && last_imm_q == 16'hffff)
      |-> res == {24'h00_0000, last_a_q[15:0]})
    else $error("gather with full mask did not copy low half");

  a_upper_tie_first: assert property (@(posedge clk) disable iff (!arst_n) // RL15
    (last_valid_q && !last_xor_q && last_op_q == DUAL_MAX_SELECT_OP && last_a_q[31:16] == last_b_q[31:16])
      |-> (upper_path_history[0] == 1'b0 && res[31:16] == last_a_q[31:16]))
    else $error("upper tie did not keep first source");

  a_xor_left_two: assert property (@(posedge clk) disable iff (!arst_n) // RL10
    (last_valid_q && last_xor_q && last_imm_q[5:0] == 6'h02)
      |-> res == (last_dstv_q ^ (last_a_q << 2)))
    else $error("xor with positive shift of two wrong");

endmodule

// ==== acs_pkg.sv ====
// shared constants and types for the bit-field and add-compare-select datapath
package acs_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int ACC_W    = 40;
  localparam int SRC_W    = 32;
  localparam int HALF_W   = 16;
  localparam int HI_W     = 24;
  localparam int GUARD_W  = 8;
  localparam int MASK_W   = 16;
  localparam int NUM_ACC  = 4;
  localparam int SEL_W    = 2;
  localparam int SHIFT_W  = 6;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int HI_LSB   = 16;
  localparam int HI_MSB   = 39;
  localparam int LO_MSB   = 15;
  localparam int SRC_MSB  = 31;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [ACC_W-1:0]  ACC_RST  = 40'h00_0000_0000;
  localparam logic [HALF_W-1:0] DIST_RST = 16'h0000;
  localparam logic [HALF_W-1:0] HIST_RST = 16'h0000;

  // ---------------------------------------------------------------
  // encoder reference, constraint length five, rate one half
  // ---------------------------------------------------------------
  localparam int            CONSTRAINT_LEN = 5;
  localparam logic [4:0]    GEN0_TAPS      = 5'h19;
  localparam logic [4:0]    GEN1_TAPS      = 5'h1b;

  // ---------------------------------------------------------------
  // operations
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NOP,
    OP_LOAD,
    OP_SET_DISTANCE,
    SCATTER_OPCODE,
    GATHER_OPCODE,
    DUAL_ADD_SUB_OP,
    DUAL_SUB_ADD_OP,
    DUAL_MAX_SELECT_OP
  } op_t;

  typedef enum logic {
    FIELD_SCATTER,
    FIELD_GATHER
  } field_mode_t;

endpackage

// ==== dual_half_if.sv ====
// operands and results between the issue logic and the dual half-word engine
`timescale 1ns/1ps
interface dual_half_if;
  import acs_pkg::*;

  logic [SRC_W-1:0]  pair_word;
  logic [HALF_W-1:0] local_distance;
  logic [SRC_W-1:0]  cmp_a;
  logic [SRC_W-1:0]  cmp_b;
  logic [ACC_W-1:0]  add_sub_res;
  logic [ACC_W-1:0]  sub_add_res;
  logic [ACC_W-1:0]  max_res;
  logic              sel_hi;
  logic              sel_lo;

  modport issuer (
    output pair_word, local_distance, cmp_a, cmp_b,
    input  add_sub_res, sub_add_res, max_res, sel_hi, sel_lo
  );

  modport engine (
    input  pair_word, local_distance, cmp_a, cmp_b,
    output add_sub_res, sub_add_res, max_res, sel_hi, sel_lo
  );
endinterface

// ==== bitfield_unit.sv ====
// single-cycle scatter and gather of accumulator bits under a 16-bit mask
`timescale 1ns/1ps
module bitfield_unit
  import acs_pkg::*;
(
  input  wire logic [SRC_W-1:0]  src,
  input  wire logic [MASK_W-1:0] mask,
  input  wire field_mode_t       mode,
  output logic      [MASK_W-1:0] result
);

  // ---------------------------------------------------------------
  // pointer walk, unrolled by the loop into one combinational layer
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [4:0] src_ptr;
    logic [4:0] dst_ptr;
    src_ptr = 5'h00;
    dst_ptr = 5'h00;
    result  = '0;
    for (int i = 0; i < MASK_W; i++)
    begin
      if (mask[i])
      begin
        result[dst_ptr[3:0]] = src[src_ptr];
        src_ptr = src_ptr + 5'h01;
        dst_ptr = dst_ptr + 5'h01;
      end
      else if (mode == FIELD_SCATTER)
      begin
        dst_ptr = dst_ptr + 5'h01; // RL1
      end
      else
      begin
        src_ptr = src_ptr + 5'h01; // RL2
      end
    end
  end

endmodule

// ==== dual_acs_engine.sv ====
// dual 16-bit add-subtract, subtract-add and max-select
`timescale 1ns/1ps
module dual_acs_engine
  import acs_pkg::*;
(
  dual_half_if.engine io
);

  logic [HI_W-1:0]   hi_ext;
  logic [HI_W-1:0]   dist_ext;
  logic [HALF_W-1:0] hi_a;
  logic [HALF_W-1:0] hi_b;
  logic [HALF_W-1:0] lo_a;
  logic [HALF_W-1:0] lo_b;

  // ---------------------------------------------------------------
  // paired metric update, halves computed independently
  // ---------------------------------------------------------------
  assign hi_ext   = {{GUARD_W{io.pair_word[SRC_MSB]}}, io.pair_word[SRC_MSB:HI_LSB]};
  assign dist_ext = {{GUARD_W{io.local_distance[HALF_W-1]}}, io.local_distance};

  assign io.add_sub_res = {hi_ext + dist_ext, io.pair_word[LO_MSB:0] - io.local_distance}; // RL4 RL5 RL13
  assign io.sub_add_res = {hi_ext - dist_ext, io.pair_word[LO_MSB:0] + io.local_distance}; // RL6 RL13

  // ---------------------------------------------------------------
  // compare each half independently; a tie keeps the first source
  // ---------------------------------------------------------------
  assign hi_a = io.cmp_a[SRC_MSB:HI_LSB];
  assign hi_b = io.cmp_b[SRC_MSB:HI_LSB];
  assign lo_a = io.cmp_a[LO_MSB:0];
  assign lo_b = io.cmp_b[LO_MSB:0];

  assign io.sel_hi  = $signed(hi_b) > $signed(hi_a); // RL7 RL15
  assign io.sel_lo  = $signed(lo_b) > $signed(lo_a); // RL7 RL15
  assign io.max_res = {{GUARD_W{io.sel_hi ? hi_b[HALF_W-1] : hi_a[HALF_W-1]}},
                       io.sel_hi ? hi_b : hi_a,
                       io.sel_lo ? lo_b : lo_a}; // RL8

endmodule

// ==== op_issue_model.sv ====
// issue-side model: instruction issue and operand selection feeding the datapath
`timescale 1ns/1ps
module op_issue_model
  import acs_pkg::*;
(
  input  wire logic             clk,
  output logic                  op_valid,
  output op_t                   opcode,
  output logic [SEL_W-1:0]      src_a_sel,
  output logic [SEL_W-1:0]      src_b_sel,
  output logic [SEL_W-1:0]      dst_sel,
  output logic [MASK_W-1:0]     select_mask_immediate,
  output logic                  xor_shift_en,
  output logic [ACC_W-1:0]      load_data
);
  initial
  begin
    op_valid = 1'b0;
    opcode = OP_NOP;
    src_a_sel = 2'h0;
    src_b_sel = 2'h0;
    dst_sel = 2'h0;
    select_mask_immediate = 16'h0000;
    xor_shift_en = 1'b0;
    load_data = 40'h00_0000_0000;
  end

  // one op per call; calls in a row land on consecutive edges
  task automatic issue(input op_t op, input logic [1:0] a, input logic [1:0] b, input logic [1:0] d,
                       input logic [15:0] imm, input logic xs, input logic [39:0] ld);
    @(negedge clk);
    op_valid <= 1'b1;
    opcode <= op;
    src_a_sel <= a;
    src_b_sel <= b;
    dst_sel <= d;
    select_mask_immediate <= imm;
    xor_shift_en <= xs;
    load_data <= ld;
    @(posedge clk);
  endtask

  task automatic idle();
    @(negedge clk);
    op_valid <= 1'b0;
    xor_shift_en <= 1'b0;
  endtask

  // expected bits coded antipodally: 0 -> +1, 1 -> -1
  function automatic logic [15:0] local_dist(input logic [15:0] sd0, input logic [15:0] sd1,
                                             input logic g0, input logic g1);
    return (g0 ? 16'h0000 - sd0 : sd0) + (g1 ? 16'h0000 - sd1 : sd1);
  endfunction

  // distance register written at least one edge before a dual op reads it
  task automatic load_distance(input logic [15:0] ld);
    issue(OP_SET_DISTANCE, 2'h0, 2'h0, 2'h0, ld, 1'b0, 40'h00_0000_0000);
  endtask
endmodule

// ==== bitfield_and_viterbi_acs_unit_bench.sv ====
// self-checking bench for the bit-field and add-compare-select datapath
`timescale 1ns/1ps
module bitfield_and_viterbi_acs_unit_bench;
  import acs_pkg::*;
  logic                          clk;
  logic                          arst_n;
  logic                          op_valid;
  op_t                           opcode;
  logic [SEL_W-1:0]              src_a_sel;
  logic [SEL_W-1:0]              src_b_sel;
  logic [SEL_W-1:0]              dst_sel;
  logic [MASK_W-1:0]             select_mask_immediate;
  logic                          xor_shift_en;
  logic [ACC_W-1:0]              load_data;
  logic [NUM_ACC-1:0][ACC_W-1:0] acc_out;
  logic [HALF_W-1:0]             distance_temp_register;
  logic [HALF_W-1:0]             upper_path_history;
  logic [HALF_W-1:0]             lower_path_history;
  int                            bad_count;
  int                            checks_done;

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  op_issue_model u_op_issue_model (.clk(clk), .op_valid(op_valid), .opcode(opcode), .src_a_sel(src_a_sel),
    .src_b_sel(src_b_sel), .dst_sel(dst_sel), .select_mask_immediate(select_mask_immediate),
    .xor_shift_en(xor_shift_en), .load_data(load_data));

  bitfield_and_viterbi_acs_unit u_bitfield_and_viterbi_acs_unit (.clk(clk), .arst_n(arst_n),
    .op_valid(op_valid), .opcode(opcode), .src_a_sel(src_a_sel), .src_b_sel(src_b_sel), .dst_sel(dst_sel),
    .select_mask_immediate(select_mask_immediate), .xor_shift_en(xor_shift_en), .load_data(load_data),
    .acc_out(acc_out), .distance_temp_register(distance_temp_register),
    .upper_path_history(upper_path_history), .lower_path_history(lower_path_history));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic iss(input op_t o, input logic [1:0] a, input logic [1:0] d, input logic [15:0] imm,
                     input logic [39:0] ld);
    u_op_issue_model.issue(o, a, 2'h0, d, imm, 1'b0, ld);
  endtask

  // pointer walk: set bit moves both, clear bit moves only the scanning side
  function automatic logic [39:0] field_ref(input logic [39:0] s, input logic [15:0] m, input logic gather);
    int          sp;
    int          dp;
    logic [39:0] r;
    sp = 0;
    dp = 0;
    r = 40'h00_0000_0000;
    for (int i = 0; i < 16; i++)
    begin
      if (m[i])
      begin
        r[dp] = s[sp];
        sp++;
        dp++;
      end
      else if (gather)
        sp++;
      else
        dp++;
    end
    return r;
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_bitfield();
    logic [15:0] masks [6];
    logic [39:0] s;
    masks = '{16'h0000, 16'hffff, 16'h5555, 16'h8001, 16'hf0f0, 16'haaaa};
    s = 40'hff_a5c3_9e71;
    iss(OP_LOAD, 2'h0, 2'h0, 16'h0000, s);
    foreach (masks[i])
    begin
      iss(SCATTER_OPCODE, 2'h0, 2'h1, masks[i], 40'h0);
      iss(GATHER_OPCODE, 2'h0, 2'h2, masks[i], 40'h0);
      u_op_issue_model.idle();
      check(acc_out[1], field_ref(s, masks[i], 1'b0));
      check(acc_out[2], field_ref(s, masks[i], 1'b1));
    end
    $display("test bitfield done");
  endtask

  task automatic t_dual();
    logic [39:0] words [2];
    logic [15:0] d;
    logic [15:0] hi;
    logic [15:0] lo;
    words = '{40'h00_7ff0_0005, 40'h00_8010_fff0};
    d = u_op_issue_model.local_dist(16'h0030, 16'h0010, 1'b0, 1'b1);
    foreach (words[w])
    begin
      hi = words[w][31:16];
      lo = words[w][15:0];
      iss(OP_LOAD, 2'h0, 2'h0, 16'h0000, words[w]);
      if (w == 0)
        u_op_issue_model.load_distance(d);
      iss(DUAL_ADD_SUB_OP, 2'h0, 2'h1, 16'h0000, 40'h0);
      iss(DUAL_SUB_ADD_OP, 2'h0, 2'h2, 16'h0000, 40'h0);
      u_op_issue_model.idle();
      check({24'h0, distance_temp_register}, 40'h00_0000_0020);
      check(acc_out[1], {{{8{hi[15]}}, hi} + {{8{d[15]}}, d}, lo - d});
      check(acc_out[2], {{{8{hi[15]}}, hi} - {{8{d[15]}}, d}, lo + d});
    end
    $display("test dual done");
  endtask

  task automatic t_max();
    logic [39:0] pa [3];
    logic [39:0] pb [3];
    logic [15:0] he;
    logic [15:0] le;
    logic        sh;
    logic        sl;
    logic [15:0] wh;
    logic [15:0] wl;
    pa = '{40'h00_0100_fff0, 40'h00_8000_1234, 40'h5a_4321_8765};
    pb = '{40'h00_00ff_0010, 40'h00_ffff_1234, 40'h00_4321_8765};
    he = 16'h0000;
    le = 16'h0000;
    foreach (pa[i])
    begin
      iss(OP_LOAD, 2'h0, 2'h0, 16'h0000, pa[i]);
      iss(OP_LOAD, 2'h0, 2'h1, 16'h0000, pb[i]);
      u_op_issue_model.issue(DUAL_MAX_SELECT_OP, 2'h0, 2'h1, 2'h3, 16'h0000, 1'b0, 40'h0);
      u_op_issue_model.idle();
      sh = $signed(pb[i][31:16]) > $signed(pa[i][31:16]);
      sl = $signed(pb[i][15:0]) > $signed(pa[i][15:0]);
      wh = sh ? pb[i][31:16] : pa[i][31:16];
      wl = sl ? pb[i][15:0] : pa[i][15:0];
      he = {he[14:0], sh};
      le = {le[14:0], sl};
      check(acc_out[3], {{8{wh[15]}}, wh, wl});
      check({24'h0, upper_path_history}, {24'h0, he});
      check({24'h0, lower_path_history}, {24'h0, le});
    end
    $display("test max select done");
  endtask

  task automatic t_xor();
    logic [39:0] x;
    logic [39:0] e0;
    logic [39:0] e1;
    x = 40'h00_9e37_79b9;
    e0 = x;
    e1 = x;
    iss(OP_LOAD, 2'h0, 2'h1, 16'h0000, x);
    iss(OP_LOAD, 2'h0, 2'h0, 16'h0000, x);
    iss(OP_LOAD, 2'h0, 2'h2, 16'h0000, x);
    for (int k = 1; k < CONSTRAINT_LEN; k++)
    begin
      if (GEN0_TAPS[k])
      begin
        u_op_issue_model.issue(OP_NOP, 2'h1, 2'h0, 2'h0, 16'(-k), 1'b1, 40'h0);
        e0 = e0 ^ (x >> k);
      end
      if (GEN1_TAPS[k])
      begin
        u_op_issue_model.issue(OP_NOP, 2'h1, 2'h0, 2'h2, 16'(-k), 1'b1, 40'h0);
        e1 = e1 ^ (x >> k);
      end
    end
    u_op_issue_model.idle();
    check(acc_out[0], e0);
    check(acc_out[2], e1);
    // positive count shifts left; upper immediate bits must not count, opcode is overridden
    u_op_issue_model.issue(GATHER_OPCODE, 2'h1, 2'h0, 2'h0, 16'hffc2, 1'b1, 40'h0);
    u_op_issue_model.idle();
    check(acc_out[0], e0 ^ (x << 2));
    $display("test xor shift done");
  endtask

  // ----------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------
  initial
  begin
    bad_count = 0;
    checks_done = 0;
    arst_n = 1'b0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    t_bitfield();
    t_dual();
    t_max();
    t_xor();
    close_out();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("MISMATCH t=%0t seen=%h expected=%h", $time, 1'b0, 1'b1);
    close_out();
  end
endmodule
